/* File: verilog/pwr_mgmt_regs.svh */
/*
  Register offsets, field positions, reset values and timing figures for the
  power-mode and wake-detect block. Assumes inclusion by bare name.
*/
`ifndef PWR_MGMT_REGS_SVH
`define PWR_MGMT_REGS_SVH

`define REG_PDCTL 12'h000
`define REG_WAKECTL 12'h004
`define REG_EDTIMEOUT 12'h008
`define REG_STATUS 12'h00C
`define REG_MACLO 12'h010
`define REG_MACHI 12'h014
`define REG_ENDUR 12'h018

`define PD_MODE_HI 4
`define PD_MODE_LO 3
`define PD_PORT_HI 12
`define PD_PORT_LO 8

`define WK_MAGIC_EN 0
`define WK_ENERGY_EN 1
`define WK_LINK_EN 2
`define WK_PIN_EN 3
`define WK_IRQ_EN 4

`define ST_MAGIC 0
`define ST_ENERGY 1
`define ST_LINK 2

`define EDTIMEOUT_RST 32'h0001_E848
`define ENDUR_RST 32'h0000_0020
`define ENERGY_MIN_NS 100
`define CLK_PERIOD_NS 8
`define ENERGY_MIN_CYC ((`ENERGY_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define SYNC_BYTE 8'hFF
`define SYNC_COUNT 6
`define MAC_REPEATS 16
`define MAC_BYTES 6

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* File: verilog/pwr_mgmt_pkg.sv */
/*
  Types for the power-mode and wake-detect block. Assumes nothing else.
*/
package pwr_mgmt_pkg;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_IDLE_ENERGY_POWERDOWN, MODE_SOFT_PD} gmode_t;
  typedef enum logic [1:0] {ED_NORMAL, ED_LOW} edstate_t;
  typedef enum logic [1:0] {MP_SYNC, MP_ADDR, MP_DONE} mpstate_t;
endpackage

/* File: verilog/power_mode_and_wake_detect.sv */
/*
  Global power mode control, energy-detect sequencing and wake detection,
  with an AXI4-Lite register slave. Assumes a received-byte stream with
  start/end/CRC status from one MAC and energy/link levels from the PHYs,
  all synchronous to CORE_CLK.
*/
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "pwr_mgmt_regs.svh"
module power_mode_and_wake_detect
  import pwr_mgmt_pkg::*;
#(
  parameter int NPORTS = 5,
  parameter int PULSE_PERIOD = 2000000,
  parameter logic [47:0] NODE_MAC_RST = 48'h0200_0000_0001
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // axi4-lite write address, data and response
  input wire logic [11:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // axi4-lite read
  input wire logic [11:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // phy and mac status
  input wire logic [NPORTS-1:0] ENERGY_IN,
  input wire logic [NPORTS-1:0] LINK_UP_IN,
  input wire logic [7:0] RX_BYTE,
  input wire logic RX_VALID,
  input wire logic RX_SOF,
  input wire logic RX_EOF,
  input wire logic RX_CRC_OK,
  input wire logic RX_FOR_NODE,
  input wire logic [7:0] STRAP_IN,
  // power controls
  output logic PLL_EN,
  output logic MAC_EN,
  output logic HOST_IF_EN,
  output logic [NPORTS-1:0] PHY_EN,
  output logic [NPORTS-1:0] RX_ED_EN,
  output logic LINK_PULSE,
  output logic [7:0] STRAP_CFG,
  // host notification
  output logic WAKE_EVENT_OUT_N,
  output logic HOST_IRQ_OUT_N
);
  localparam int ADDR_CNT_W = $clog2(`MAC_BYTES * `MAC_REPEATS + 1);
  localparam int ED_MIN = `ENERGY_MIN_CYC;

  typedef struct packed {
    logic aw_got;
    logic [11:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] mode_field;
    gmode_t gmode;
    logic [NPORTS-1:0] port_pd;
    logic [4:0] wake_ctl;
    logic [31:0] ed_timeout;
    logic [31:0] en_dur;
    logic [47:0] node_mac;
    logic [2:0] wake_st;
    edstate_t ed_st;
    logic [31:0] idle_cnt;
    logic [31:0] pres_cnt;
    logic [31:0] pulse_cnt;
    logic [31:0] wen_cnt;
    logic [NPORTS-1:0] link_prev;
    mpstate_t mp_st;
    logic [2:0] sync_cnt;
    logic [ADDR_CNT_W-1:0] addr_cnt;
    logic strap_load;
    logic [7:0] strap_cfg;
    logic pulse;
    logic wake_n;
    logic irq_n;
  } state_t;

  state_t q, d;
  logic any_energy;
  logic wr_fire;
  logic [47:0] wmask;
  logic [7:0] exp_byte;

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    d = q;
    any_energy = |ENERGY_IN;
    wmask = 48'h0;
    exp_byte = q.node_mac[8'(47 - 8 * (q.addr_cnt % `MAC_BYTES)) -: 8];
    d.pulse = 1'b0;
    d.strap_load = 1'b0;

    // write channel: address and data taken in either order
    if (AWVALID && !q.aw_got) begin
      d.aw_got = 1'b1;
      d.aw_addr = AWADDR;
    end
    if (WVALID && !q.w_got) begin
      d.w_got = 1'b1;
      d.w_data = WDATA;
      d.w_strb = WSTRB;
    end
    wr_fire = q.aw_got && q.w_got && !q.bvalid;
    if (wr_fire) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `RESP_OKAY;
      // register writes stay accepted in every mode so software can wake us
      unique case (q.aw_addr)
        `REG_PDCTL: begin
          d.mode_field = 2'(merge({19'h0, q.port_pd, 3'h0, q.mode_field, 3'h0},
            q.w_data, q.w_strb) >> `PD_MODE_LO);
          d.port_pd = NPORTS'(merge({19'h0, q.port_pd, 8'h0}, q.w_data,
            q.w_strb) >> `PD_PORT_LO);
        end
        `REG_WAKECTL: d.wake_ctl = 5'(merge({27'h0, q.wake_ctl}, q.w_data, q.w_strb));
        `REG_EDTIMEOUT: d.ed_timeout = merge(q.ed_timeout, q.w_data, q.w_strb);
        `REG_ENDUR: d.en_dur = merge(q.en_dur, q.w_data, q.w_strb);
        `REG_MACLO: d.node_mac[31:0] = merge(q.node_mac[31:0], q.w_data, q.w_strb);
        `REG_MACHI: begin
          d.node_mac[47:32] = 16'(merge({16'h0, q.node_mac[47:32]}, q.w_data, q.w_strb));
        end
        `REG_STATUS: begin
          wmask[2:0] = q.w_data[2:0] & {3{q.w_strb[0]}};
        end
        default: d.bresp = `RESP_SLVERR;
      endcase
    end
    if (q.bvalid && BREADY) begin
      d.bvalid = 1'b0;
    end

    // read channel
    if (ARVALID && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rresp = `RESP_OKAY;
      unique case (ARADDR)
        `REG_PDCTL: d.rdata = {19'h0, q.port_pd, 3'h0, q.mode_field, 3'h0};
        `REG_WAKECTL: d.rdata = {27'h0, q.wake_ctl};
        `REG_EDTIMEOUT: d.rdata = q.ed_timeout;
        `REG_STATUS: d.rdata = {28'h0, q.ed_st == ED_LOW, q.wake_st};
        `REG_MACLO: d.rdata = q.node_mac[31:0];
        `REG_MACHI: d.rdata = {16'h0, q.node_mac[47:32]};
        `REG_ENDUR: d.rdata = q.en_dur;
        default: begin
          d.rdata = 32'h0;
          d.rresp = `RESP_SLVERR;
        end
      endcase
    end else if (q.rvalid && RREADY) begin
      d.rvalid = 1'b0;
    end

    // mode decode: three modes, 11 held as normal
    unique case (d.mode_field)
      2'b01: d.gmode = MODE_IDLE_ENERGY_POWERDOWN;
      2'b10: d.gmode = MODE_SOFT_PD;
      default: d.gmode = MODE_NORMAL;
    endcase

    // leaving soft power-down: back to defaults, restrap next cycle
    if (q.gmode == MODE_SOFT_PD && d.gmode != MODE_SOFT_PD) begin
      d.port_pd = '0;
      d.wake_ctl = 5'h0;
      d.ed_timeout = `EDTIMEOUT_RST;
      d.en_dur = `ENDUR_RST;
      d.node_mac = NODE_MAC_RST;
      d.strap_load = 1'b1;
    end
    if (q.strap_load) begin
      d.strap_cfg = STRAP_IN;
    end

    // energy-detect sequencing
    if (q.gmode != MODE_IDLE_ENERGY_POWERDOWN) begin
      d.ed_st = ED_NORMAL;
      d.idle_cnt = 32'h0;
      d.pres_cnt = 32'h0;
    end else begin
      unique case (q.ed_st)
        ED_NORMAL: begin
          d.idle_cnt = any_energy ? 32'h0 : q.idle_cnt + 32'h1;
          if (!any_energy && q.idle_cnt >= q.ed_timeout) begin
            d.ed_st = ED_LOW;
            d.pres_cnt = 32'h0;
          end
        end
        ED_LOW: begin
          d.pres_cnt = any_energy ? q.pres_cnt + 32'h1 : 32'h0;
          if (any_energy && q.pres_cnt >= 32'(ED_MIN)) begin
            d.ed_st = ED_NORMAL;
            d.idle_cnt = 32'h0;
          end
        end
        default: d.ed_st = ED_NORMAL;
      endcase
    end

    // sparse link pulses, one cycle each per period
    if (q.ed_st == ED_LOW) begin
      d.pulse_cnt = (q.pulse_cnt >= 32'(PULSE_PERIOD - 1)) ? 32'h0 : q.pulse_cnt + 32'h1;
      d.pulse = (q.pulse_cnt == 32'h0);
    end else begin
      d.pulse_cnt = 32'h0;
    end

    // wake-packet scanner over the whole frame
    if (!q.wake_ctl[`WK_MAGIC_EN] || q.gmode == MODE_SOFT_PD || (RX_VALID && RX_SOF)) begin
      d.mp_st = MP_SYNC;
      d.sync_cnt = 3'h0;
      d.addr_cnt = '0;
    end
    if (q.wake_ctl[`WK_MAGIC_EN] && RX_VALID && RX_FOR_NODE) begin
      unique case (RX_SOF ? MP_SYNC : q.mp_st)
        MP_SYNC: begin
          if (RX_BYTE == `SYNC_BYTE) begin
            if ((RX_SOF ? 3'h0 : q.sync_cnt) >= 3'(`SYNC_COUNT - 1)) begin
              d.mp_st = MP_ADDR;
              d.sync_cnt = 3'(`SYNC_COUNT);
            end else begin
              d.sync_cnt = (RX_SOF ? 3'h0 : q.sync_cnt) + 3'h1;
            end
            d.addr_cnt = '0;
          end else begin
            d.sync_cnt = 3'h0;
          end
        end
        MP_ADDR: begin
          if (RX_BYTE == exp_byte) begin
            if (q.addr_cnt == ADDR_CNT_W'(`MAC_BYTES * `MAC_REPEATS - 1)) begin
              d.mp_st = MP_DONE;
            end else begin
              d.addr_cnt = q.addr_cnt + 1'b1;
            end
          end else if (RX_BYTE == `SYNC_BYTE && q.addr_cnt == '0) begin
            d.mp_st = MP_ADDR;
          end else begin
            d.mp_st = MP_SYNC;
            d.sync_cnt = (RX_BYTE == `SYNC_BYTE) ? 3'h1 : 3'h0;
            d.addr_cnt = '0;
          end
        end
        MP_DONE: d.mp_st = MP_DONE;
        default: d.mp_st = MP_SYNC;
      endcase
    end

    // energy duration counter for wake
    d.wen_cnt = any_energy ? ((q.wen_cnt == 32'hFFFF_FFFF) ? q.wen_cnt : q.wen_cnt + 32'h1)
      : 32'h0;
    d.link_prev = LINK_UP_IN;

    // sticky wake status; a new event wins over the clear
    d.wake_st = q.wake_st & ~wmask[2:0];
    if (q.wake_ctl[`WK_MAGIC_EN] && q.mp_st == MP_DONE && RX_VALID && RX_EOF && RX_CRC_OK) begin
      d.wake_st[`ST_MAGIC] = 1'b1;
    end
    if (q.wake_ctl[`WK_ENERGY_EN] && any_energy && q.wen_cnt == q.en_dur) begin
      d.wake_st[`ST_ENERGY] = 1'b1;
    end
    if (q.wake_ctl[`WK_LINK_EN] && |(LINK_UP_IN & ~q.link_prev)) begin
      d.wake_st[`ST_LINK] = 1'b1;
    end
    if (q.mp_st == MP_DONE && RX_VALID && RX_EOF) begin
      d.mp_st = MP_SYNC;
      d.sync_cnt = 3'h0;
      d.addr_cnt = '0;
    end
    d.wake_n = !(q.wake_ctl[`WK_PIN_EN] && |q.wake_st);
    d.irq_n = !(q.wake_ctl[`WK_IRQ_EN] && |q.wake_st);
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      q <= '0;
      q.gmode <= MODE_NORMAL;
      q.ed_st <= ED_NORMAL;
      q.mp_st <= MP_SYNC;
      q.ed_timeout <= `EDTIMEOUT_RST;
      q.en_dur <= `ENDUR_RST;
      q.node_mac <= NODE_MAC_RST;
      q.strap_load <= 1'b1;
      q.wake_n <= 1'b1;
      q.irq_n <= 1'b1;
      PLL_EN <= 1'b1;
      MAC_EN <= 1'b1;
      HOST_IF_EN <= 1'b1;
      PHY_EN <= '1;
      RX_ED_EN <= '1;
    end else begin
      q <= d;
      PLL_EN <= d.gmode == MODE_NORMAL || (d.gmode == MODE_IDLE_ENERGY_POWERDOWN && d.ed_st == ED_NORMAL);
      MAC_EN <= d.gmode == MODE_NORMAL || (d.gmode == MODE_IDLE_ENERGY_POWERDOWN && d.ed_st == ED_NORMAL);
      HOST_IF_EN <= d.gmode == MODE_NORMAL || (d.gmode == MODE_IDLE_ENERGY_POWERDOWN && d.ed_st == ED_NORMAL);
      PHY_EN <= (d.gmode == MODE_NORMAL || (d.gmode == MODE_IDLE_ENERGY_POWERDOWN && d.ed_st == ED_NORMAL))
        ? ~d.port_pd : '0;
      RX_ED_EN <= (d.gmode == MODE_SOFT_PD) ? '0 : ~d.port_pd;
    end
  end

  assign AWREADY = q.aw_got == 1'b0;
  assign WREADY = q.w_got == 1'b0;
  assign BVALID = q.bvalid;
  assign BRESP = q.bresp;
  assign ARREADY = !q.rvalid;
  assign RVALID = q.rvalid;
  assign RDATA = q.rdata;
  assign RRESP = q.rresp;
  assign LINK_PULSE = q.pulse;
  assign STRAP_CFG = q.strap_cfg;
  assign WAKE_EVENT_OUT_N = q.wake_n;
  assign HOST_IRQ_OUT_N = q.irq_n;

  a_soft_pd_off: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    q.gmode == MODE_SOFT_PD |-> !PLL_EN && !MAC_EN && PHY_EN == '0 && RX_ED_EN == '0)
    else $error("soft power-down left a function enabled");
  a_low_pll_off: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    q.ed_st == ED_LOW && q.gmode == MODE_IDLE_ENERGY_POWERDOWN |-> !PLL_EN && !MAC_EN && !HOST_IF_EN)
    else $error("low-power state left clock running");
  a_mode_decode: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    q.mode_field == 2'b01 |-> q.gmode == MODE_IDLE_ENERGY_POWERDOWN)
    else $error("mode 01 not energy-detect");
  a_normal_decode: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    q.mode_field == 2'b00 |-> q.gmode == MODE_NORMAL && PLL_EN)
    else $error("mode 00 not normal");
  a_wake_pin: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    q.wake_ctl[`WK_PIN_EN] && |q.wake_st |=> !WAKE_EVENT_OUT_N)
    else $error("wake output not asserted");
  a_wake_quiet: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    !q.wake_ctl[`WK_PIN_EN] |=> WAKE_EVENT_OUT_N)
    else $error("wake output asserted while disabled");
  a_irq_path: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    q.wake_ctl[`WK_IRQ_EN] && |q.wake_st |=> !HOST_IRQ_OUT_N)
    else $error("interrupt not asserted");
  a_ed_exit: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    q.ed_st == ED_LOW && !any_energy |=> q.ed_st == ED_LOW || q.gmode != MODE_IDLE_ENERGY_POWERDOWN)
    else $error("left low power without energy");
  a_magic_needs_en: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    $rose(q.wake_st[`ST_MAGIC]) |-> $past(q.wake_ctl[`WK_MAGIC_EN]))
    else $error("wake packet flagged while disabled");
  a_port_pd: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    q.gmode == MODE_NORMAL && d.gmode == MODE_NORMAL |=> PHY_EN == ~q.port_pd)
    else $error("port power-down not applied");
endmodule

/* File: dv/link_partner_model.sv */
/*
  Link-side model: per-port energy and link levels, and the received byte
  stream of one MAC. Assumes a free-running CORE_CLK from the bench.
*/
`timescale 1ns/1ps
module link_partner_model #(
  parameter int NPORTS = 5
) (
  // clock
  input wire logic CORE_CLK,
  // phy levels
  output logic [NPORTS-1:0] ENERGY_IN,
  output logic [NPORTS-1:0] LINK_UP_IN,
  // received bytes
  output logic [7:0] RX_BYTE,
  output logic RX_VALID,
  output logic RX_SOF,
  output logic RX_EOF,
  output logic RX_CRC_OK,
  output logic RX_FOR_NODE
);
  initial begin
    ENERGY_IN = '0;
    LINK_UP_IN = '0;
    RX_BYTE = 8'h00;
    RX_VALID = 1'b0;
    RX_SOF = 1'b0;
    RX_EOF = 1'b0;
    RX_CRC_OK = 1'b0;
    RX_FOR_NODE = 1'b0;
  end

  task automatic energy_burst(input int n);
    @(posedge CORE_CLK);
    ENERGY_IN <= '1;
    repeat (n) @(posedge CORE_CLK);
    ENERGY_IN <= '0;
  endtask

  task automatic link_up(input int p);
    @(posedge CORE_CLK);
    LINK_UP_IN[p] <= 1'b1;
  endtask

  // broadcast frame; a lone 0xFF and a header sit before the sync run
  task automatic send_frame(input logic [47:0] mac, input int copies, input logic crc_ok,
                            input logic for_node);
    logic [7:0] q[$];
    int i;
    q = {8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h02, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55,
         8'h08, 8'h00, 8'h45, 8'hFF, 8'h12};
    repeat (6) q.push_back(8'hFF);
    repeat (copies) for (i = 5; i >= 0; i--) q.push_back(mac[i*8 +: 8]);
    repeat (4) q.push_back(8'hC3);
    for (i = 0; i < q.size(); i++) begin
      @(posedge CORE_CLK);
      RX_VALID <= 1'b1;
      RX_BYTE <= q[i];
      RX_SOF <= (i == 0);
      RX_EOF <= (i == q.size() - 1);
      RX_CRC_OK <= (i == q.size() - 1) && crc_ok;
      RX_FOR_NODE <= for_node;
    end
    @(posedge CORE_CLK);
    RX_VALID <= 1'b0;
    RX_SOF <= 1'b0;
    RX_EOF <= 1'b0;
    RX_CRC_OK <= 1'b0;
    RX_FOR_NODE <= 1'b0;
    // idle bus shows changed data so a stale byte is never mistaken for input
    RX_BYTE <= ~q[q.size()-1];
  endtask
endmodule

/* File: dv/power_mode_and_wake_detect_test.sv */
/*
  Self-checking bench: AXI4-Lite register tasks plus mode, low-power and
  wake scenarios. Assumes the design package, register header and model.
*/
`timescale 1ns/1ps
`include "pwr_mgmt_regs.svh"
module power_mode_and_wake_detect_test
  import pwr_mgmt_pkg::*;
;
  localparam logic [47:0] node_mac = 48'h0A1B_2C3D_4E5F;
  logic core_clk = 1'b0;
  logic reset_n;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [4:0] energy, link_up, phy_en, rx_ed_en;
  logic [7:0] rx_byte, strap_in, strap_cfg;
  logic rx_valid, rx_sof, rx_eof, rx_crc_ok, rx_for_node;
  logic pll_en, mac_en, host_if_en, link_pulse, wake_n, irq_n;
  logic [4:0] cases [5] = '{5'b11111, 5'b11010, 5'b10110, 5'b11100, 5'b01110};
  logic [4:0] c;
  int n_fail = 0;
  int n_compared = 0;
  int pulses = 0;
  int p0, k;

  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) if (link_pulse === 1'b1) pulses++;

  power_mode_and_wake_detect #(.PULSE_PERIOD(20)) dut_u (
    .CORE_CLK(core_clk), .RESET_N(reset_n),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready),
    .ENERGY_IN(energy), .LINK_UP_IN(link_up), .RX_BYTE(rx_byte), .RX_VALID(rx_valid),
    .RX_SOF(rx_sof), .RX_EOF(rx_eof), .RX_CRC_OK(rx_crc_ok), .RX_FOR_NODE(rx_for_node),
    .STRAP_IN(strap_in), .PLL_EN(pll_en), .MAC_EN(mac_en), .HOST_IF_EN(host_if_en),
    .PHY_EN(phy_en), .RX_ED_EN(rx_ed_en), .LINK_PULSE(link_pulse), .STRAP_CFG(strap_cfg),
    .WAKE_EVENT_OUT_N(wake_n), .HOST_IRQ_OUT_N(irq_n)
  );

  link_partner_model #(.NPORTS(5)) partner_u (
    .CORE_CLK(core_clk), .ENERGY_IN(energy), .LINK_UP_IN(link_up), .RX_BYTE(rx_byte),
    .RX_VALID(rx_valid), .RX_SOF(rx_sof), .RX_EOF(rx_eof), .RX_CRC_OK(rx_crc_ok),
    .RX_FOR_NODE(rx_for_node)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string s);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, s, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // let the edge's updates land before outputs are looked at
  task automatic pause(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // requests change just after a rising edge and are judged at the next rising edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    logic aw_on, w_on;
    aw_on = 1'b1;
    w_on = 1'b1;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (aw_on && awready === 1'b1) begin
        aw_on = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_on && wready === 1'b1) begin
        w_on = 1'b0;
        wvalid <= 1'b0;
      end
    end while (bvalid !== 1'b1);
    r = bresp;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_on;
    ar_on = 1'b1;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (ar_on && arready === 1'b1) begin
        ar_on = 1'b0;
        arvalid <= 1'b0;
      end
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask

  task automatic w(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, 4'hF, r);
    chk(r, `RESP_OKAY, "bresp");
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string s);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(r, `RESP_OKAY, s);
    chk(d & m, e, s);
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    $display("watchdog expired at %0t", $time);
    end_of_test();
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    awaddr = '0;
    wdata = '0;
    wstrb = '0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b0;
    strap_in = 8'h5A;
    reset_n = 1'b0;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    pause(3);
    chk({pll_en, mac_en, host_if_en, wake_n, irq_n, link_pulse}, 6'h3E, "reset outs");
    chk(phy_en, 5'h1F, "phys on");
    chk(strap_cfg, 8'h5A, "straps");
    rchk(`REG_PDCTL, 32'h18, 32'h0, "mode");
    rchk(`REG_EDTIMEOUT, '1, `EDTIMEOUT_RST, "timeout");
    wr(`REG_EDTIMEOUT, 32'hFFFF_FF33, 4'h1, r);
    chk(r, `RESP_OKAY, "strobe wr");
    rchk(`REG_EDTIMEOUT, '1, (`EDTIMEOUT_RST & 32'hFFFF_FF00) | 32'h0000_0033, "strobe");
    rd(12'h100, d, r);
    chk({r, d}, {`RESP_SLVERR, 32'h0}, "unmapped rd");
    wr(12'h100, 32'h1, 4'hF, r);
    chk(r, `RESP_SLVERR, "unmapped wr");
    w(`REG_PDCTL, 32'h0000_0500);
    pause(3);
    chk({pll_en, phy_en}, {1'b1, 5'h1A}, "port pd");
    $display("test reset_map_port done");
    w(`REG_EDTIMEOUT, 32'd10);
    w(`REG_PDCTL, 32'h0000_0510);
    pause(3);
    chk({pll_en, mac_en, host_if_en, phy_en, rx_ed_en}, 13'h0, "soft pd");
    rchk(`REG_EDTIMEOUT, '1, 32'd10, "mgmt alive");
    @(posedge core_clk) strap_in <= 8'hA5;
    w(`REG_PDCTL, 32'h0);
    pause(3);
    chk({strap_cfg, pll_en, phy_en}, {8'hA5, 1'b1, 5'h1F}, "soft pd exit");
    rchk(`REG_EDTIMEOUT, '1, `EDTIMEOUT_RST, "defaults");
    rchk(`REG_PDCTL, 32'h1F00, 32'h0, "port pd default");
    $display("test soft_powerdown done");
    w(`REG_EDTIMEOUT, 32'd10);
    w(`REG_PDCTL, 32'h08);
    pause(30);
    chk({pll_en, mac_en, host_if_en, rx_ed_en}, {3'b000, 5'h1F}, "low power");
    rchk(`REG_STATUS, 32'h8, 32'h8, "lp state");
    p0 = pulses;
    pause(65);
    chk((pulses - p0) inside {[2:4]}, 1'b1, "link pulses");
    partner_u.energy_burst(5);
    pause(3);
    chk(pll_en, 1'b0, "short energy");
    partner_u.energy_burst(20);
    pause(1);
    chk(pll_en, 1'b1, "energy return");
    w(`REG_PDCTL, 32'h0);
    pause(30);
    chk({pll_en, mac_en, host_if_en}, 3'h7, "normal again");
    $display("test energy_detect done");
    w(`REG_MACLO, node_mac[31:0]);
    w(`REG_MACHI, {16'h0, node_mac[47:32]});
    for (k = 0; k < 5; k++) begin
      c = cases[k];
      w(`REG_WAKECTL, c[4] ? 32'h9 : 32'h8);
      partner_u.send_frame(node_mac, c[3] ? 16 : 15, c[2], c[1]);
      pause(4);
      chk(wake_n, !c[0], "wake pin");
      rchk(`REG_STATUS, 32'h1, {31'h0, c[0]}, "wake status");
      w(`REG_STATUS, 32'h1);
      pause(3);
      chk(wake_n, 1'b1, "wake cleared");
    end
    $display("test wake_packet done");
    w(`REG_WAKECTL, 32'h14);
    partner_u.link_up(2);
    pause(4);
    chk({wake_n, irq_n}, 2'b10, "irq path");
    rchk(`REG_STATUS, 32'h4, 32'h4, "link event");
    w(`REG_STATUS, 32'h4);
    pause(3);
    chk(irq_n, 1'b1, "irq cleared");
    w(`REG_WAKECTL, 32'h12);
    partner_u.energy_burst(40);
    pause(3);
    chk(irq_n, 1'b0, "energy irq");
    rchk(`REG_STATUS, 32'h2, 32'h2, "energy event");
    $display("test wake_events done");
    end_of_test();
  end
endmodule
